// ---- rtl/gfr_pkg.sv ----
// package of constants and carrier types for the global fault record block
package gfr_pkg;
  // register byte offsets
  localparam logic [7:0] GFR_OFF_ACTIVE = 8'h00;
  localparam logic [7:0] GFR_OFF_ADDR_LO = 8'h04;
  localparam logic [7:0] GFR_OFF_ADDR_HI = 8'h08;
  localparam logic [7:0] GFR_OFF_FLAGS = 8'h0c;
  localparam logic [7:0] GFR_OFF_RESTORE = 8'h10;
  localparam logic [7:0] GFR_OFF_NS_ADDR_LO = 8'h14;
  localparam logic [7:0] GFR_OFF_NS_ADDR_HI = 8'h18;
  localparam logic [7:0] GFR_OFF_NS_FLAGS = 8'h1c;
  localparam logic [7:0] GFR_OFF_NS_RESTORE = 8'h20;
  localparam logic [7:0] GFR_OFF_IRQ_MASK = 8'h24;
  // field positions
  localparam int GFR_BIT_MULTI = 31;
  localparam int GFR_BIT_UNSUP = 8;
  localparam int GFR_BIT_PERM = 7;
  // implemented bit masks
  localparam logic [31:0] GFR_MASK_V2 = 32'h8000_01ff;
  localparam logic [31:0] GFR_MASK_V1 = 32'h8000_00ff;
  localparam logic [31:0] GFR_MASK_NS_CLR = 32'hffff_ff7f;
  // reset values of control state and response codes
  localparam logic [31:0] GFR_RST_FLAGS = 32'h0000_0000;
  localparam logic [1:0] GFR_RESP_OKAY = 2'h0;
  localparam logic [1:0] GFR_RESP_SLVERR = 2'h2;
  // one recorded fault from the translation logic
  typedef struct packed {
    logic valid;
    logic secure;
    logic ctxBank;
    logic [8:0] classes;
    logic [63:0] addr;
  } gfr_fault_t;
endpackage

// ---- rtl/gfr_bank.sv ----
// one security bank: fault flags and fault address
module gfr_bank
  import gfr_pkg::*;
#(
  parameter int ADDR_W = 40,
  parameter logic [31:0] IMPL_MASK = GFR_MASK_V2
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // fault event
  input wire logic faultHit,
  input wire logic [8:0] faultClasses,
  input wire logic [63:0] faultAddr,
  // software access
  input wire logic clrWr,
  input wire logic restoreWr,
  input wire logic addrLoWr,
  input wire logic addrHiWr,
  input wire logic [31:0] wrData,
  input wire logic [3:0] wrStrb,
  // state
  output logic [31:0] flags,
  output logic [63:0] addr
);
  logic [31:0] flags_r;
  logic [ADDR_W-1:0] addr_r;
  logic [31:0] newBits;
  logic [63:0] addrWide;
  logic [31:0] strbMask;
  logic [63:0] addrWr;

  // elaboration check on the address width
  if (ADDR_W < 32 || ADDR_W > 64) begin : g_bad_width
    $error("gfr_bank: ADDR_W out of range");
  end

  // byte enables to bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      strbMask[i*8 +: 8] = {8{wrStrb[i]}};
    end
  end

  // new flag bits with multiple error
  always_comb begin
    newBits = {23'h0, faultClasses} & IMPL_MASK;
    newBits[GFR_BIT_MULTI] = (flags_r != 32'h0);
  end

  // flags: restore, clear then set, set wins
  always_ff @(posedge clk) begin
    if (reset) begin
      flags_r <= GFR_RST_FLAGS;
    end else if (restoreWr) begin
      flags_r <= wrData & IMPL_MASK;
    end else begin
      flags_r <= (flags_r & ~(clrWr ? (wrData & strbMask) : 32'h0)) | (faultHit ? newBits : 32'h0);
    end
  end

  // address: software write or capture on first error
  always_ff @(posedge clk) begin
    if (faultHit && flags_r == 32'h0) begin
      addr_r <= faultAddr[ADDR_W-1:0];
    end else if (addrLoWr) begin
      addr_r <= ADDR_W'((addrWr & ~{32'h0, strbMask}) | {32'h0, wrData & strbMask});
    end else if (addrHiWr) begin
      addr_r <= ADDR_W'((addrWr & ~{strbMask, 32'h0}) | {wrData & strbMask, 32'h0});
    end
  end

  assign flags = flags_r;
  assign addrWide = 64'(addr_r);
  assign addrWr = addrWide; // zero-extended view for partial word writes
  assign addr = addrWide;

  chk_multi_set: assert property (@(posedge clk) disable iff (reset)
    (faultHit && !restoreWr && flags_r != 32'h0) |=> flags_r[GFR_BIT_MULTI])
    else $error("multi bit not set on repeated error");
  chk_addr_keep: assert property (@(posedge clk) disable iff (reset)
    (faultHit && flags_r != 32'h0 && !addrLoWr && !addrHiWr) |=> $stable(addr_r))
    else $error("address changed on repeated error");
  chk_clear_w1c: assert property (@(posedge clk) disable iff (reset)
    (clrWr && !faultHit && !restoreWr) |=> ((flags_r & $past(wrData & strbMask)) == 32'h0))
    else $error("write one did not clear flag");
  chk_restore_val: assert property (@(posedge clk) disable iff (reset)
    restoreWr |=> flags_r == $past(wrData & IMPL_MASK))
    else $error("restore value not loaded");
endmodule

// ---- rtl/gfr_irq.sv ----
// sticky interrupt status and mask for block events
module gfr_irq
  import gfr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // events and software
  input wire logic [1:0] events,
  input wire logic [1:0] clrBits,
  input wire logic maskWr,
  input wire logic [1:0] maskData,
  // state
  output logic [1:0] status,
  output logic [1:0] mask,
  output logic irq
);
  logic [1:0] status_r;
  logic [1:0] mask_r;

  // sticky status, set wins over clear
  always_ff @(posedge clk) begin
    if (reset) status_r <= 2'h0;
    else status_r <= (status_r & ~clrBits) | events;
  end

  // mask register
  always_ff @(posedge clk) begin
    if (reset) mask_r <= 2'h0;
    else if (maskWr) mask_r <= maskData;
  end

  assign status = status_r;
  assign mask = mask_r;
  assign irq = |(status_r & mask_r);
endmodule

// ---- rtl/gfr_top.sv ----
// global fault record: banked fault flags and address behind an AXI4-Lite slave
//
// The address map and register access over AXI4-Lite were decided locally.
module gfr_top
  import gfr_pkg::*;
#(
  parameter bit VERSION_TWO = 1'b1,
  parameter bit TWO_STATES = 1'b1,
  parameter int UPSTREAM_BUS_W = 48,
  parameter int INPUT_SPACE_W = 40
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awprot1,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arprot1,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // fault reports and translation status
  input wire gfr_fault_t fault,
  input wire logic translateStart,
  input wire logic resultWritten,
  // interrupt
  output logic irq
);
  localparam int ADDR_W = VERSION_TWO ? UPSTREAM_BUS_W : INPUT_SPACE_W;
  localparam logic [31:0] IMPL_MASK = VERSION_TWO ? GFR_MASK_V2 : GFR_MASK_V1;

  // elaboration checks on the configuration
  if (!VERSION_TWO && INPUT_SPACE_W != 32 && INPUT_SPACE_W != 36 && INPUT_SPACE_W != 40) begin : g_bad_space
    $error("gfr_top: input space width must be 32, 36 or 40");
  end
  if (ADDR_W < 32 || ADDR_W > 64) begin : g_bad_width
    $error("gfr_top: address width out of range");
  end

  // write and read channel holding registers, active flag
  logic awHeld_r;
  logic wHeld_r;
  logic [7:0] awAddr_r;
  logic awSec_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic bValid_r;
  logic [1:0] bResp_r;
  logic rValid_r;
  logic [31:0] rData_r;
  logic [1:0] rResp_r;
  logic active_r;
  logic doWrite;

  // decode of a register offset to a bank access
  function automatic logic [3:0] decodeOff(input logic [7:0] off, input logic sec);
    logic [3:0] d;
    d = 4'h0; // {ns alias, bank kind hit, secure bank, valid}
    if (off inside {GFR_OFF_ACTIVE, GFR_OFF_ADDR_LO, GFR_OFF_ADDR_HI, GFR_OFF_FLAGS,
                    GFR_OFF_RESTORE, GFR_OFF_IRQ_MASK}) begin
      d = {1'b0, 1'b1, sec && TWO_STATES, 1'b1};
    end else if (TWO_STATES && sec && off inside {GFR_OFF_NS_ADDR_LO, GFR_OFF_NS_ADDR_HI,
                    GFR_OFF_NS_FLAGS, GFR_OFF_NS_RESTORE}) begin
      d = 4'b1101;
    end
    return d;
  endfunction

  // alias offsets map onto the plain ones
  function automatic logic [7:0] baseOff(input logic [7:0] off);
    logic [7:0] b;
    b = off;
    if (off >= GFR_OFF_NS_ADDR_LO && off <= GFR_OFF_NS_RESTORE) b = 8'(off - 8'h10);
    return b;
  endfunction

  // write address capture
  always_ff @(posedge clk) begin
    if (reset) begin
      awHeld_r <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_r <= 1'b1;
    end else if (doWrite) begin
      awHeld_r <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (s_axi_awvalid && s_axi_awready) begin
      awAddr_r <= s_axi_awaddr;
      awSec_r <= ~s_axi_awprot1;
    end
  end

  // write data capture
  always_ff @(posedge clk) begin
    if (reset) begin
      wHeld_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_r <= 1'b1;
    end else if (doWrite) begin
      wHeld_r <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (s_axi_wvalid && s_axi_wready) begin
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
    end
  end

  assign s_axi_awready = !awHeld_r && !bValid_r;
  assign s_axi_wready = !wHeld_r && !bValid_r;
  assign doWrite = awHeld_r && wHeld_r && !bValid_r;

  // write decode
  logic [3:0] wDec;
  logic [7:0] wOff;
  logic wSecBank;
  assign wDec = decodeOff(awAddr_r, awSec_r);
  assign wOff = baseOff(awAddr_r);
  assign wSecBank = wDec[1] && !wDec[3];
  logic [1:0] clrWr, restoreWr, addrLoWr, addrHiWr;
  logic maskWr;
  always_comb begin
    clrWr = 2'h0;
    restoreWr = 2'h0;
    addrLoWr = 2'h0;
    addrHiWr = 2'h0;
    maskWr = 1'b0;
    if (doWrite && wDec[0]) begin
      clrWr[wSecBank] = (wOff == GFR_OFF_FLAGS);
      restoreWr[wSecBank] = (wOff == GFR_OFF_RESTORE);
      addrLoWr[wSecBank] = (wOff == GFR_OFF_ADDR_LO);
      addrHiWr[wSecBank] = (wOff == GFR_OFF_ADDR_HI);
      maskWr = (wOff == GFR_OFF_IRQ_MASK);
    end
  end

  // write response
  always_ff @(posedge clk) begin
    if (reset) begin
      bValid_r <= 1'b0;
      bResp_r <= GFR_RESP_OKAY;
    end else if (doWrite) begin
      bValid_r <= 1'b1;
      bResp_r <= wDec[0] ? GFR_RESP_OKAY : GFR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_r <= 1'b0;
    end
  end
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;

  // fault routing to banks; context-bank faults stay out
  logic [1:0] faultHit;
  logic [8:0] classes;
  always_comb begin
    classes = fault.classes;
    if (!fault.secure || !TWO_STATES) classes[GFR_BIT_PERM] = 1'b0;
    faultHit = 2'h0;
    if (fault.valid && !fault.ctxBank) begin
      faultHit[fault.secure && TWO_STATES] = 1'b1;
    end
  end

  // bank instances
  logic [31:0] flags [2];
  logic [63:0] fault_input_address [2];
  for (genvar b = 0; b < 2; b++) begin : g_bank
    gfr_bank #(
      .ADDR_W(ADDR_W),
      .IMPL_MASK(b == 1 ? IMPL_MASK : (IMPL_MASK & GFR_MASK_NS_CLR))
    ) u_bank (
      .clk(clk),
      .reset(reset),
      .faultHit(faultHit[b]),
      .faultClasses(classes),
      .faultAddr(fault.addr),
      .clrWr(clrWr[b]),
      .restoreWr(restoreWr[b]),
      .addrLoWr(addrLoWr[b]),
      .addrHiWr(addrHiWr[b]),
      .wrData(wData_r),
      .wrStrb(wStrb_r),
      .flags(flags[b]),
      .addr(fault_input_address[b])
    );
  end

  // translation in progress flag
  always_ff @(posedge clk) begin
    if (reset) active_r <= 1'b0;
    else if (translateStart) active_r <= 1'b1;
    else if (resultWritten) active_r <= 1'b0;
  end

  // interrupt: fault recorded in each bank
  logic [1:0] irqStatus, irqMask;
  gfr_irq u_irq (
    .clk(clk),
    .reset(reset),
    .events(faultHit),
    .clrBits(clrWr[1] ? wData_r[1:0] & {2{wStrb_r[0]}} : 2'h0),
    .maskWr(maskWr),
    .maskData(wData_r[1:0]),
    .status(irqStatus),
    .mask(irqMask),
    .irq(irq)
  );

  // read path
  logic [3:0] rDec;
  logic [7:0] rOff;
  logic rSecBank;
  assign rDec = decodeOff(s_axi_araddr, ~s_axi_arprot1);
  assign rOff = baseOff(s_axi_araddr);
  assign rSecBank = rDec[1] && !rDec[3];
  assign s_axi_arready = !rValid_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      rValid_r <= 1'b0;
      rData_r <= 32'h0;
      rResp_r <= GFR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_r <= 1'b1;
      rResp_r <= rDec[0] ? GFR_RESP_OKAY : GFR_RESP_SLVERR;
      unique case (rOff)
        GFR_OFF_ACTIVE: rData_r <= {31'h0, active_r};
        GFR_OFF_ADDR_LO: rData_r <= fault_input_address[rSecBank][31:0];
        GFR_OFF_ADDR_HI: rData_r <= fault_input_address[rSecBank][63:32];
        GFR_OFF_FLAGS: rData_r <= flags[rSecBank];
        GFR_OFF_IRQ_MASK: rData_r <= {14'h0, irqStatus, 14'h0, irqMask};
        default: rData_r <= 32'h0;
      endcase
      if (!rDec[0]) rData_r <= 32'h0;
    end else if (s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

  chk_active_flag: assert property (@(posedge clk) disable iff (reset)
    translateStart |=> active_r)
    else $error("active flag not raised");
  chk_ctx_bank: assert property (@(posedge clk) disable iff (reset)
    (fault.valid && fault.ctxBank) |-> faultHit == 2'h0)
    else $error("context bank fault reached global status");
  chk_ns_perm: assert property (@(posedge clk) disable iff (reset)
    ##1 !flags[0][GFR_BIT_PERM])
    else $error("permission bit set in non-secure bank");
  chk_unsup_v1: assert property (@(posedge clk) disable iff (reset)
    (faultHit[1] && !restoreWr[1] && fault.classes[GFR_BIT_UNSUP])
      |=> flags[1][GFR_BIT_UNSUP] == IMPL_MASK[GFR_BIT_UNSUP])
    else $error("unsupported bit set in version one");
  chk_addr_upper: assert property (@(posedge clk) disable iff (reset)
    ##1 ((fault_input_address[1] >> ADDR_W) == 64'h0))
    else $error("address upper bits not zero");
  chk_resp_once: assert property (@(posedge clk) disable iff (reset)
    doWrite |=> s_axi_bvalid)
    else $error("write response missing");
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the global fault record block with a register model
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import gfr_pkg::*;
  localparam logic [63:0] ADDR_MASK = 64'h0000_ffff_ffff_ffff;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awprot1 = 1'b0, s_axi_arprot1 = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  gfr_fault_t fault = '0;
  logic translateStart = 1'b0, resultWritten = 1'b0;
  int error_cnt = 0, samples_checked = 0;
  // behavioural register model
  logic [31:0] mFlags [2];
  logic [63:0] mAddr [2];
  logic mAct = 1'b0;
  logic [1:0] mIrqSt = '0, mMask = '0;
  gfr_top dut (.clk(clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot1(s_axi_awprot1),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot1(s_axi_arprot1), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fault(fault),
    .translateStart(translateStart), .resultWritten(resultWritten), .irq(irq));
  // clock generation
  always #12.5 clk = ~clk;
  task automatic wrap_up();
    if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_val({31'h0, got}, {31'h0, exp});
  endtask
  // implemented flag bits of each bank
  function automatic logic [31:0] bmask(input int b);
    return b ? GFR_MASK_V2 : (GFR_MASK_V2 & GFR_MASK_NS_CLR);
  endfunction
  // bank and local offset of an access; 0 when refused
  function automatic bit map(input logic [7:0] a, input logic p, output int b, output logic [7:0] off);
    b = p ? 0 : 1;
    off = a;
    if (a >= 8'h14 && a <= 8'h20) begin
      b = 0;
      off = a - 8'h10;
      if (p) return 0;
    end
    return (off <= 8'h10 || off == 8'h24) && off[1:0] == 2'h0;
  endfunction
  task automatic chk_irq();
    @(negedge clk);
    cmp_bit(irq, |(mIrqSt & mMask));
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic p, input logic [31:0] d);
    logic ha, hw, hb;
    logic [1:0] resp;
    int b;
    logic [7:0] off;
    bit ok;
    s_axi_awaddr <= a;
    s_axi_awprot1 <= p;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    hb = 1'b0;
    for (int t = 0; t < 200 && !hb; t++) begin
      @(negedge clk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
    if (!hb) error_cnt++;
    ok = map(a, p, b, off);
    cmp_val({30'h0, resp}, {30'h0, ok ? GFR_RESP_OKAY : GFR_RESP_SLVERR});
    if (ok) begin
      case (off)
        8'h04: mAddr[b] = {mAddr[b][63:32], d} & ADDR_MASK;
        8'h08: mAddr[b] = {d, mAddr[b][31:0]} & ADDR_MASK;
        8'h0c: begin
          mFlags[b] &= ~d;
          if (a == 8'h0c && b == 1) mIrqSt &= ~d[1:0];
        end
        8'h10: mFlags[b] = d & bmask(b);
        8'h24: mMask = d[1:0];
        default: ;
      endcase
    end
    chk_irq();
  endtask
  task automatic rd(input logic [7:0] a, input logic p);
    logic har, hr;
    logic [31:0] data, exp;
    logic [1:0] resp;
    int b;
    logic [7:0] off;
    bit ok;
    s_axi_araddr <= a;
    s_axi_arprot1 <= p;
    s_axi_arvalid <= 1'b1;
    hr = 1'b0;
    for (int t = 0; t < 200 && !hr; t++) begin
      @(negedge clk);
      har = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (har) s_axi_arvalid <= 1'b0;
    end
    if (!hr) error_cnt++;
    ok = map(a, p, b, off);
    case (off)
      8'h00: exp = {31'h0, mAct};
      8'h04: exp = mAddr[b][31:0];
      8'h08: exp = mAddr[b][63:32];
      8'h0c: exp = mFlags[b];
      8'h24: exp = {14'h0, mIrqSt, 14'h0, mMask};
      default: exp = '0;
    endcase
    cmp_val({30'h0, resp}, {30'h0, ok ? GFR_RESP_OKAY : GFR_RESP_SLVERR});
    cmp_val(data, ok ? exp : 32'h0);
  endtask
  // one fault report pulse, then the model follows
  task automatic flt(input logic sec, input logic ctx, input logic [8:0] cls, input logic [63:0] a);
    int b;
    fault <= '{1'b1, sec, ctx, cls, a};
    @(posedge clk);
    fault <= '0;
    @(posedge clk);
    b = sec ? 1 : 0;
    if (!ctx) begin
      if (mFlags[b] != 0) mFlags[b][GFR_BIT_MULTI] = 1'b1;
      else mAddr[b] = a & ADDR_MASK;
      mFlags[b] |= {23'h0, cls} & bmask(b);
      mIrqSt[b] = 1'b1;
    end
    chk_irq();
  endtask
  task automatic pulse(input bit start);
    if (start) translateStart <= 1'b1;
    else resultWritten <= 1'b1;
    @(posedge clk);
    translateStart <= 1'b0;
    resultWritten <= 1'b0;
    @(posedge clk);
    mAct = start;
  endtask
  // watchdog
  initial begin
    #(25 * 20000);
    error_cnt++;
    wrap_up();
  end
  initial begin
    mFlags[0] = '0;
    mFlags[1] = '0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    void'($urandom(32'h34fa197e));
    rd(8'h00, 1'b0);
    rd(8'h0c, 1'b0);
    rd(8'h24, 1'b0);
    pulse(1'b1);
    rd(8'h00, 1'b0);
    pulse(1'b0);
    rd(8'h00, 1'b1);
    wr(8'h24, 1'b0, 32'h0000_0000);
    flt(1'b1, 1'b0, 9'h1a5, {$urandom, $urandom});
    wr(8'h24, 1'b0, 32'h0000_0003);
    rd(8'h24, 1'b0);
    rd(8'h04, 1'b0);
    rd(8'h08, 1'b0);
    flt(1'b1, 1'b0, 9'h002, {$urandom, $urandom});
    rd(8'h0c, 1'b0);
    rd(8'h04, 1'b0);
    flt(1'b0, 1'b0, 9'h0ff, {$urandom, $urandom});
    rd(8'h0c, 1'b1);
    rd(8'h1c, 1'b0);
    rd(8'h14, 1'b0);
    rd(8'h14, 1'b1);
    flt(1'b1, 1'b1, 9'h011, {$urandom, $urandom});
    rd(8'h0c, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(8'h0c, i[0], $urandom);
      rd(8'h0c, i[0]);
    end
    wr(8'h10, 1'b0, $urandom);
    rd(8'h0c, 1'b0);
    wr(8'h20, 1'b0, $urandom);
    rd(8'h0c, 1'b1);
    wr(8'h10, 1'b1, 32'hffff_ffff);
    rd(8'h10, 1'b1);
    flt(1'b0, 1'b0, 9'h040, {$urandom, $urandom});
    wr(8'h04, 1'b1, $urandom);
    wr(8'h08, 1'b1, $urandom);
    rd(8'h14, 1'b0);
    rd(8'h18, 1'b0);
    wr(8'h18, 1'b0, $urandom);
    rd(8'h08, 1'b1);
    wr(8'h14, 1'b1, $urandom);
    wr(8'h28, 1'b0, $urandom);
    rd(8'hfc, 1'b0);
    wr(8'h0c, 1'b0, 32'h0000_0003);
    rd(8'h24, 1'b0);
    wrap_up();
  end
endmodule
